// ===== ssw_pkg.sv
// Package for the supply switch status and event register bank.
// Assumes an Avalon-MM slave with 32-bit data and byte addresses.
`default_nettype none
package ssw_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [13:0] SSW_IDX_CTRL = 14'h1C00;
    localparam logic [13:0] SSW_IDX_STS = 14'h1C01;
    localparam logic [13:0] SSW_IDX_FLAGS = 14'h1C02;
    localparam logic [13:0] SSW_IDX_ENABLES = 14'h1C03;
    localparam logic [13:0] SSW_IDX_STATE = 14'h1C04;
    // Status register fields
    localparam int SSW_STS_ALW_OK = 5;
    localparam int SSW_STS_BUS_OK = 4;
    localparam int SSW_STS_RAILS = 2;
    localparam int SSW_STS_ALW_GATE = 1;
    localparam int SSW_STS_BUS_GATE = 0;
    // Event flag and enable fields
    localparam int SSW_EV_TO_BUS = 5;
    localparam int SSW_EV_TO_ALW = 4;
    localparam int SSW_EV_ALW_LOST = 3;
    localparam int SSW_EV_ALW_UP = 2;
    localparam int SSW_EV_BUS_LOST = 1;
    localparam int SSW_EV_BUS_UP = 0;
    // Switch state fields
    localparam int SSW_ST_BUS_SW = 1;
    localparam int SSW_ST_ALW_SW = 0;
    // Control fields
    localparam int SSW_CTL_FORCE = 0;
    localparam int SSW_CTL_SW_EN_N = 1;
    // Implemented bits per register
    localparam logic [7:0] SSW_MASK_CTRL = 8'h03;
    localparam logic [7:0] SSW_MASK_STS = 8'h37;
    localparam logic [7:0] SSW_MASK_EV = 8'h3F;
    localparam logic [7:0] SSW_MASK_STATE = 8'h03;
    // Values after reset
    localparam logic [7:0] SSW_RST_CTRL = 8'h00;
    localparam logic [7:0] SSW_RST_STS = 8'h04;
    localparam logic [7:0] SSW_RST_EV = 8'h00;
    localparam logic [7:0] SSW_RST_STATE = 8'h00;
    // Selected source, Gray coded along none, always-on, bus
    typedef enum logic [1:0] {
        SSW_SRC_NONE = 2'b00,
        SSW_SRC_ALW = 2'b01,
        SSW_SRC_BUS = 2'b11
    } ssw_src_t;
endpackage
`default_nettype wire

// ===== ssw_bank.sv
// Supply switch status, event flag, enable and state registers.
// Assumes supply detector and sequencer levels synchronous to CLK.
`timescale 1ns/1ps
`default_nettype none
module ssw_bank (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Avalon-MM slave
    input wire logic [15:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Supply detectors and comparators
    input wire logic ALWAYS_ON_SUPPLY_OK,
    input wire logic BUS_SUPPLY_OK,
    input wire logic RAILS_GOOD,
    input wire logic ALWAYS_ON_GATE_OFF,
    input wire logic BUS_GATE_OFF,
    // Switch sequencer
    input wire logic ALWAYS_ON_SWITCH_ON,
    input wire logic BUS_SWITCH_ON,
    output logic FORCE_BUS_SOURCE,
    output logic SWITCH_ENABLE_N,
    // System
    output logic SUPPLY_IRQ,
    output logic WAKE_REQ
);
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] sts_reg;
    logic [7:0] sts_next;
    logic [7:0] flag_reg;
    logic [7:0] flag_next;
    logic [7:0] en_reg;
    logic [7:0] en_next;
    logic [7:0] state_reg;
    logic [7:0] state_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic wait_reg;
    logic wait_next;
    logic irq_reg;
    logic irq_next;
    logic wake_reg;
    logic wake_next;
    ssw_pkg::ssw_src_t src_reg;
    ssw_pkg::ssw_src_t src_next;

    // Bus handshake: one wait cycle per access
    wire req = AVS_READ | AVS_WRITE;
    wire first = req & wait_reg;
    wire take = req & ~wait_reg;
    wire wr_take = take & AVS_WRITE & AVS_BYTEENABLE[0];
    wire [13:0] widx = AVS_ADDRESS[15:2];
    wire sel_ctrl = widx == ssw_pkg::SSW_IDX_CTRL;
    wire sel_sts = widx == ssw_pkg::SSW_IDX_STS;
    wire sel_flags = widx == ssw_pkg::SSW_IDX_FLAGS;
    wire sel_en = widx == ssw_pkg::SSW_IDX_ENABLES;
    wire sel_state = widx == ssw_pkg::SSW_IDX_STATE;
    wire wr_ctrl = wr_take & sel_ctrl;
    wire wr_flags = wr_take & sel_flags;
    wire wr_en = wr_take & sel_en;
    wire [7:0] wbyte = AVS_WRITEDATA[7:0];

    // Unmapped addresses read zero, writes dropped
    wire [7:0] rd_byte =
        sel_ctrl ? ctrl_reg :
        sel_sts ? sts_reg :
        sel_flags ? flag_reg :
        sel_en ? en_reg :
        sel_state ? state_reg : 8'h00;
    assign rdata_next = (first & AVS_READ) ? {24'h000000, rd_byte} : rdata_reg;
    assign wait_next = ~first;

    // Control: force bus source and switch enable, to the sequencer
    assign ctrl_next = wr_ctrl ? (wbyte & ssw_pkg::SSW_MASK_CTRL) : ctrl_reg;
    wire force_on = ctrl_reg[ssw_pkg::SSW_CTL_FORCE];
    wire force_rise = ctrl_next[ssw_pkg::SSW_CTL_FORCE] & ~force_on;

    // Live status, one register stage from the detectors
    assign sts_next = {
        2'b00,
        ALWAYS_ON_SUPPLY_OK,
        BUS_SUPPLY_OK,
        1'b0,
        RAILS_GOOD,
        ALWAYS_ON_GATE_OFF,
        BUS_GATE_OFF
    };
    assign state_next = {6'b000000, BUS_SWITCH_ON, ALWAYS_ON_SWITCH_ON};
    wire alw_ok_n = sts_next[ssw_pkg::SSW_STS_ALW_OK];
    wire alw_ok_q = sts_reg[ssw_pkg::SSW_STS_ALW_OK];
    wire bus_ok_n = sts_next[ssw_pkg::SSW_STS_BUS_OK];
    wire bus_ok_q = sts_reg[ssw_pkg::SSW_STS_BUS_OK];

    // Source tracking; overlap or gap in the switches keeps the last source
    wire alw_only = ALWAYS_ON_SWITCH_ON & ~BUS_SWITCH_ON;
    wire bus_only = BUS_SWITCH_ON & ~ALWAYS_ON_SWITCH_ON;
    always_comb begin
        case (src_reg)
            ssw_pkg::SSW_SRC_NONE: begin
                src_next = alw_only ? ssw_pkg::SSW_SRC_ALW :
                    bus_only ? ssw_pkg::SSW_SRC_BUS : ssw_pkg::SSW_SRC_NONE;
            end
            ssw_pkg::SSW_SRC_ALW: begin
                src_next = bus_only ? ssw_pkg::SSW_SRC_BUS : ssw_pkg::SSW_SRC_ALW;
            end
            ssw_pkg::SSW_SRC_BUS: begin
                src_next = alw_only ? ssw_pkg::SSW_SRC_ALW : ssw_pkg::SSW_SRC_BUS;
            end
            default: begin
                src_next = ssw_pkg::SSW_SRC_NONE;
            end
        endcase
    end
    wire to_bus = (src_reg == ssw_pkg::SSW_SRC_ALW) & bus_only;
    wire to_alw = (src_reg == ssw_pkg::SSW_SRC_BUS) & alw_only;
    wire alw_hold = force_on & ~bus_ok_n & alw_ok_n;
    wire to_alw_ok = to_alw & ~alw_hold;

    // Events this cycle
    wire [7:0] ev = {
        2'b00,
        to_bus | force_rise,
        to_alw_ok,
        alw_ok_q & ~alw_ok_n,
        alw_ok_n & ~alw_ok_q,
        bus_ok_q & ~bus_ok_n,
        bus_ok_n & ~bus_ok_q
    };

    // Write one clears; a same-cycle event wins over the clear
    wire [7:0] flag_clr = wr_flags ? wbyte : 8'h00;
    assign flag_next = ((flag_reg & ~flag_clr) | ev) & ssw_pkg::SSW_MASK_EV;
    assign en_next = wr_en ? (wbyte & ssw_pkg::SSW_MASK_EV) : en_reg;

    // Interrupt lags the flags by one cycle so it leaves a flop
    wire [7:0] irq_src = flag_reg & en_reg;
    assign irq_next = |irq_src;
    // Wake pulses on a newly raised enabled event
    wire [7:0] wake_src = ev & en_reg;
    assign wake_next = |wake_src;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            ctrl_reg <= ssw_pkg::SSW_RST_CTRL;
            sts_reg <= ssw_pkg::SSW_RST_STS;
            flag_reg <= ssw_pkg::SSW_RST_EV;
            en_reg <= ssw_pkg::SSW_RST_EV;
            state_reg <= ssw_pkg::SSW_RST_STATE;
        end else begin
            ctrl_reg <= ctrl_next;
            sts_reg <= sts_next;
            flag_reg <= flag_next;
            en_reg <= en_next;
            state_reg <= state_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            rdata_reg <= 32'h00000000;
            wait_reg <= 1'b1;
            irq_reg <= 1'b0;
            wake_reg <= 1'b0;
            src_reg <= ssw_pkg::SSW_SRC_NONE;
        end else begin
            rdata_reg <= rdata_next;
            wait_reg <= wait_next;
            irq_reg <= irq_next;
            wake_reg <= wake_next;
            src_reg <= src_next;
        end
    end

    assign AVS_READDATA = rdata_reg;
    assign AVS_WAITREQUEST = wait_reg;
    assign FORCE_BUS_SOURCE = ctrl_reg[ssw_pkg::SSW_CTL_FORCE];
    assign SWITCH_ENABLE_N = ctrl_reg[ssw_pkg::SSW_CTL_SW_EN_N];
    assign SUPPLY_IRQ = irq_reg;
    assign WAKE_REQ = wake_reg;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    // Release edge skipped: the bank still loads reset values there
    AST_ALW_OK_MIRROR: assert property (
        !RESET |=> sts_reg[ssw_pkg::SSW_STS_ALW_OK] == $past(ALWAYS_ON_SUPPLY_OK))
        else $error("always-on ok status not mirrored");

    AST_BUS_OK_MIRROR: assert property (
        !RESET |=> sts_reg[ssw_pkg::SSW_STS_BUS_OK] == $past(BUS_SUPPLY_OK))
        else $error("bus ok status not mirrored");

    AST_RAILS_RESET: assert property (
        disable iff (1'b0) RESET |=> sts_reg[ssw_pkg::SSW_STS_RAILS])
        else $error("rails good not one after reset");

    AST_GATE_MIRROR: assert property (
        !RESET |=> sts_reg[1:0] == {$past(ALWAYS_ON_GATE_OFF), $past(BUS_GATE_OFF)})
        else $error("gate off bits not mirrored");

    AST_TO_BUS: assert property (
        (src_reg == ssw_pkg::SSW_SRC_ALW && bus_only) |=> flag_reg[ssw_pkg::SSW_EV_TO_BUS])
        else $error("to-bus flag missing");

    AST_FORCE_SETS: assert property (
        force_rise |=> flag_reg[ssw_pkg::SSW_EV_TO_BUS] && force_on)
        else $error("force did not set to-bus flag");

    AST_NO_ALW_UNDER_FORCE: assert property (
        alw_hold && !flag_reg[ssw_pkg::SSW_EV_TO_ALW] && !wr_flags
        |=> !flag_reg[ssw_pkg::SSW_EV_TO_ALW])
        else $error("to-always-on flag set under force");

    AST_ALW_LOST: assert property (
        $fell(sts_reg[ssw_pkg::SSW_STS_ALW_OK]) |-> flag_reg[ssw_pkg::SSW_EV_ALW_LOST])
        else $error("always-on lost flag missing");

    AST_BUS_UP: assert property (
        $rose(sts_reg[ssw_pkg::SSW_STS_BUS_OK]) |-> flag_reg[ssw_pkg::SSW_EV_BUS_UP])
        else $error("bus up flag missing");

    AST_W1C: assert property (
        (wr_flags && ev == 8'h00) |=>
        flag_reg == ($past(flag_reg) & ~$past(wbyte) & ssw_pkg::SSW_MASK_EV))
        else $error("flag clear wrong");

    AST_IRQ_FOLLOWS: assert property (
        1'b1 |=> SUPPLY_IRQ == $past(irq_next))
        else $error("interrupt not registered OR of enabled flags");

    AST_IRQ_HOLDS: assert property (
        (|irq_src && !wr_flags && !wr_en) [*2] |-> SUPPLY_IRQ)
        else $error("interrupt dropped with enabled flag pending");

    AST_RESERVED_ZERO: assert property (
        !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h000000 && flag_reg[7:6] == 2'b00)
        else $error("reserved bits not zero");

    AST_ONE_WAIT: assert property (
        first |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("wait cycle count wrong");

    AST_TO_ALW: assert property (
        (src_reg == ssw_pkg::SSW_SRC_BUS && alw_only && !alw_hold)
        |=> flag_reg[ssw_pkg::SSW_EV_TO_ALW])
        else $error("to-always-on flag missing");

    AST_ALW_UP: assert property (
        $rose(sts_reg[ssw_pkg::SSW_STS_ALW_OK])
        |-> flag_reg[ssw_pkg::SSW_EV_ALW_UP])
        else $error("always-on up flag missing");

    AST_BUS_LOST: assert property (
        $fell(sts_reg[ssw_pkg::SSW_STS_BUS_OK])
        |-> flag_reg[ssw_pkg::SSW_EV_BUS_LOST])
        else $error("bus lost flag missing");

    // Sticky flags drop only on a software write
    AST_FLAG_STICKY: assert property (
        !wr_flags
        |=> (flag_reg & $past(flag_reg)) == $past(flag_reg))
        else $error("flag cleared without a write");

    AST_EN_WRITE: assert property (
        wr_en
        |=> en_reg == ($past(wbyte) & ssw_pkg::SSW_MASK_EV))
        else $error("enable write wrong");

    AST_EN_HOLD: assert property (
        !wr_en
        |=> $stable(en_reg))
        else $error("enables changed without a write");

    AST_IRQ_GATED: assert property (
        irq_src == 8'h00
        |=> !SUPPLY_IRQ)
        else $error("interrupt without an enabled flag");

    AST_BUS_SW_MIRROR: assert property (
        !RESET
        |=> state_reg[ssw_pkg::SSW_ST_BUS_SW] == $past(BUS_SWITCH_ON))
        else $error("bus switch state not mirrored");

    AST_ALW_SW_MIRROR: assert property (
        !RESET
        |=> state_reg[ssw_pkg::SSW_ST_ALW_SW] == $past(ALWAYS_ON_SWITCH_ON))
        else $error("always-on switch state not mirrored");

    AST_RAILS_MIRROR: assert property (
        !RESET
        |=> sts_reg[ssw_pkg::SSW_STS_RAILS] == $past(RAILS_GOOD))
        else $error("rails good not mirrored");

    AST_RESERVED_REGS: assert property (
        sts_reg[7:6] == 2'b00 && !sts_reg[3] && en_reg[7:6] == 2'b00
        && ctrl_reg[7:2] == 6'h00 && state_reg[7:2] == 6'h00)
        else $error("reserved register bits not zero");

    // Wake is high the cycle after each enabled event; back-to-back events hold it high
    AST_WAKE_RAISED: assert property (
        wake_src != 8'h00
        |=> WAKE_REQ)
        else $error("wake request missing");

    AST_WAKE_QUIET: assert property (
        wake_src == 8'h00
        |=> !WAKE_REQ)
        else $error("wake request without an enabled event");

    // Control outputs follow the written byte
    AST_FORCE_OUT: assert property (
        wr_ctrl
        |=> FORCE_BUS_SOURCE == $past(wbyte[ssw_pkg::SSW_CTL_FORCE]))
        else $error("force output not written");

    AST_CTRL_HOLD: assert property (
        !wr_ctrl
        |=> $stable(ctrl_reg))
        else $error("control changed without a write");

    AST_SWITCH_EN_OUT: assert property (
        wr_ctrl
        |=> SWITCH_ENABLE_N == $past(wbyte[ssw_pkg::SSW_CTL_SW_EN_N]))
        else $error("switch enable output not written");

    AST_FLAG_READ: assert property (
        (first && AVS_READ && sel_flags)
        |=> AVS_READDATA == {24'h000000, $past(flag_reg)})
        else $error("flag read data wrong");

    AST_RESET_OUTPUTS: assert property (
        disable iff (1'b0) RESET
        |=> AVS_WAITREQUEST && !SUPPLY_IRQ && !WAKE_REQ && !FORCE_BUS_SOURCE && !SWITCH_ENABLE_N)
        else $error("outputs not idle after reset");

    AST_SRC_ON_PATH: assert property (
        src_reg inside {ssw_pkg::SSW_SRC_NONE, ssw_pkg::SSW_SRC_ALW, ssw_pkg::SSW_SRC_BUS})
        else $error("source tracker off its path");

    COV_TO_BUS: cover property (to_bus ##1 SUPPLY_IRQ);
    COV_FORCE: cover property (force_rise ##1 force_on);
    COV_CLEAR_RACE: cover property (wr_flags && (|(ev & wbyte)));
    COV_WAKE: cover property (WAKE_REQ);
    COV_UNDER_FORCE: cover property (to_alw && alw_hold);
endmodule // ssw_bank
`default_nettype wire

// ===== ssw_supply_model.sv
// Behavioural supply detectors and switch sequencer for the bank.
// Assumes the bench sets supply presence off the clock edge.
`timescale 1ns/1ps
`default_nettype none
module ssw_supply_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Supplies commanded by the bench
    input wire logic alw_present,
    input wire logic bus_present,
    // From the bank
    input wire logic force_bus,
    // Towards the bank
    output logic alw_ok,
    output logic bus_ok,
    output logic alw_sw_on,
    output logic bus_sw_on
);
    assign alw_ok = alw_present;
    assign bus_ok = bus_present;
    // One switch at a time, so the bank sees clean source changes
    always_ff @(posedge clk) begin
        if (reset) begin
            {bus_sw_on, alw_sw_on} <= 2'b00;
        end else if (force_bus && bus_present) begin
            {bus_sw_on, alw_sw_on} <= 2'b10;
        end else if (alw_present) begin
            {bus_sw_on, alw_sw_on} <= 2'b01;
        end else if (bus_present) begin
            {bus_sw_on, alw_sw_on} <= 2'b10;
        end else begin
            {bus_sw_on, alw_sw_on} <= 2'b00;
        end
    end
endmodule // ssw_supply_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the supply switch register bank.
// Assumes the Avalon slave answers within the watchdog span.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, reset = 1'b1, rd = 1'b0, wr = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wd = 32'h0, rdata;
    logic [3:0] be = 4'h0;
    logic wait_req, irq, wake, force_bus, sw_en_n, alw_ok, bus_ok, alw_sw, bus_sw;
    logic alw_p = 1'b0, bus_p = 1'b0, rails = 1'b1, g1 = 1'b0, g0 = 1'b0, wake_seen = 1'b0;
    int err_total = 0, comparisons = 0;
    initial forever #4 clk = ~clk;
    always @(posedge clk) if (wake === 1'b1) wake_seen <= 1'b1;
    ssw_bank u_ssw_bank (.CLK(clk), .RESET(reset), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
        .ALWAYS_ON_SUPPLY_OK(alw_ok), .BUS_SUPPLY_OK(bus_ok), .RAILS_GOOD(rails),
        .ALWAYS_ON_GATE_OFF(g1), .BUS_GATE_OFF(g0), .ALWAYS_ON_SWITCH_ON(alw_sw),
        .BUS_SWITCH_ON(bus_sw), .FORCE_BUS_SOURCE(force_bus), .SWITCH_ENABLE_N(sw_en_n),
        .SUPPLY_IRQ(irq), .WAKE_REQ(wake));
    ssw_supply_model u_ssw_supply_model (.clk(clk), .reset(reset), .alw_present(alw_p),
        .bus_present(bus_p), .force_bus(force_bus), .alw_ok(alw_ok), .bus_ok(bus_ok),
        .alw_sw_on(alw_sw), .bus_sw_on(bus_sw));
    task automatic final_report();
        if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic w, input logic [13:0] idx, input logic [7:0] d,
                       input logic [3:0] b, output logic [31:0] q);
        @(posedge clk);
        addr <= {idx, 2'b00};
        rd <= !w;
        wr <= w;
        wd <= {24'h0, d};
        be <= b;
        do begin
            @(posedge clk);
        end while (wait_req !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wr8(input logic [13:0] idx, input logic [7:0] d, input logic [3:0] b);
        logic [31:0] q;
        bus(1'b1, idx, d, b, q);
    endtask
    task automatic rdc(input logic [13:0] idx, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, 4'hF, q);
        chk(q, {24'h0, exp});
    endtask
    task automatic settle();
        repeat (4) @(posedge clk);
    endtask
    task automatic irq_is(input logic exp);
        settle();
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask
    task automatic t_reset_and_map();
        rdc(ssw_pkg::SSW_IDX_STS, ssw_pkg::SSW_RST_STS);
        rdc(ssw_pkg::SSW_IDX_FLAGS, 8'h00);
        rdc(ssw_pkg::SSW_IDX_ENABLES, 8'h00);
        rdc(ssw_pkg::SSW_IDX_STATE, 8'h00);
        wr8(14'h1C05, 8'hFF, 4'hF);
        rdc(14'h1C05, 8'h00);
        wr8(ssw_pkg::SSW_IDX_CTRL, 8'hFE, 4'hF);
        rdc(ssw_pkg::SSW_IDX_CTRL, 8'h02);
        chk({30'h0, sw_en_n, force_bus}, 32'h2);
        wr8(ssw_pkg::SSW_IDX_CTRL, 8'h00, 4'hF);
        rdc(ssw_pkg::SSW_IDX_FLAGS, 8'h00);
        @(posedge clk);
        g1 <= 1'b1;
        rails <= 1'b0;
        settle();
        rdc(ssw_pkg::SSW_IDX_STS, 8'h02);
        g1 <= 1'b0;
        g0 <= 1'b1;
        rails <= 1'b1;
        settle();
        rdc(ssw_pkg::SSW_IDX_STS, 8'h05);
        g0 <= 1'b0;
    endtask
    task automatic t_up_events_irq();
        alw_p <= 1'b1;
        settle();
        rdc(ssw_pkg::SSW_IDX_STS, 8'h24);
        rdc(ssw_pkg::SSW_IDX_FLAGS, 8'h04);
        rdc(ssw_pkg::SSW_IDX_STATE, 8'h01);
        wr8(ssw_pkg::SSW_IDX_FLAGS, 8'h04, 4'hF);
        bus_p <= 1'b1;
        settle();
        rdc(ssw_pkg::SSW_IDX_STS, 8'h34);
        rdc(ssw_pkg::SSW_IDX_FLAGS, 8'h01);
        irq_is(1'b0);
        wr8(ssw_pkg::SSW_IDX_ENABLES, 8'hFF, 4'hF);
        rdc(ssw_pkg::SSW_IDX_ENABLES, 8'h3F);
        irq_is(1'b1);
        wr8(ssw_pkg::SSW_IDX_FLAGS, 8'h00, 4'hF);
        wr8(ssw_pkg::SSW_IDX_FLAGS, 8'h3F, 4'h0);
        rdc(ssw_pkg::SSW_IDX_FLAGS, 8'h01);
        irq_is(1'b1);
        wr8(ssw_pkg::SSW_IDX_FLAGS, 8'h01, 4'hF);
        rdc(ssw_pkg::SSW_IDX_FLAGS, 8'h00);
        irq_is(1'b0);
    endtask
    task automatic t_forced_source();
        wr8(ssw_pkg::SSW_IDX_CTRL, 8'h01, 4'hF);
        settle();
        rdc(ssw_pkg::SSW_IDX_FLAGS, 8'h20);
        rdc(ssw_pkg::SSW_IDX_STATE, 8'h02);
        rdc(ssw_pkg::SSW_IDX_CTRL, 8'h01);
        chk({31'h0, force_bus}, 32'h1);
        wr8(ssw_pkg::SSW_IDX_FLAGS, 8'h20, 4'hF);
        bus_p <= 1'b0;
        settle();
        rdc(ssw_pkg::SSW_IDX_FLAGS, 8'h02);
        wr8(ssw_pkg::SSW_IDX_CTRL, 8'h00, 4'hF);
        wr8(ssw_pkg::SSW_IDX_FLAGS, 8'h02, 4'hF);
    endtask
    task automatic t_auto_source();
        bus_p <= 1'b1;
        settle();
        wr8(ssw_pkg::SSW_IDX_FLAGS, 8'h01, 4'hF);
        alw_p <= 1'b0;
        settle();
        rdc(ssw_pkg::SSW_IDX_FLAGS, 8'h28);
        rdc(ssw_pkg::SSW_IDX_STATE, 8'h02);
        wr8(ssw_pkg::SSW_IDX_FLAGS, 8'h28, 4'hF);
        alw_p <= 1'b1;
        settle();
        rdc(ssw_pkg::SSW_IDX_FLAGS, 8'h14);
        bus_p <= 1'b0;
        settle();
        rdc(ssw_pkg::SSW_IDX_FLAGS, 8'h16);
        chk({31'h0, wake_seen}, 32'h1);
    endtask
    // Always-on supply stays present, so release brings a fresh up event
    task automatic t_mid_reset();
        @(posedge clk);
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        settle();
        rdc(ssw_pkg::SSW_IDX_ENABLES, 8'h00);
        rdc(ssw_pkg::SSW_IDX_CTRL, ssw_pkg::SSW_RST_CTRL);
        rdc(ssw_pkg::SSW_IDX_STS, 8'h24);
        rdc(ssw_pkg::SSW_IDX_FLAGS, 8'h04);
        rdc(ssw_pkg::SSW_IDX_STATE, 8'h01);
        irq_is(1'b0);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        t_reset_and_map();
        t_up_events_irq();
        t_forced_source();
        t_auto_source();
        t_mid_reset();
        final_report();
    end
    // Whole sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        final_report();
    end
endmodule // tb_top
`default_nettype wire
